// >>> uied_top.v
// Purpose: three input endpoint descriptors behind a byte register port
// Assumes: buffer manager events are single-cycle pulses on this clock
// Notes:   unmapped reads return zero; writes to them are dropped
//
// Our own choice: the strobed register port.
`timescale 1ns/1ns
`include "uied_defines.vh"
module uied_top (
	// clock and reset
	input  wire        clock,
	input  wire        reset,
	// register port
	input  wire [15:0] reg_addr,
	input  wire [7:0]  reg_wdata,
	input  wire        reg_write,
	input  wire        reg_read,
	output reg  [7:0]  reg_rdata,
	// buffer manager events, one bit per endpoint 1..3
	input  wire [2:0]  bm_done,
	input  wire [2:0]  bm_stall_set,
	input  wire [2:0]  bm_stall_sent,
	input  wire [2:0]  bm_load,
	// buffer manager view, endpoint n in slice n-1
	output wire [32:0] ep_start_addr,
	output wire [20:0] ep_count,
	output wire [2:0]  ep_ready,
	output wire [2:0]  ep_usable,
	output wire [2:0]  ep_stall,
	// interrupt
	output wire        irq
);
	wire [23:0] cfg_all;
	wire [23:0] xbase_all;
	wire [23:0] xcnt_all;
	wire [23:0] ybase_all;
	wire [23:0] ycnt_all;
	wire [2:0]  hit;
	reg  [2:0]  irq_status_q;
	reg  [2:0]  irq_enable_q;
	reg  [7:0]  rd_d;
	wire [2:0]  irq_clear;
	wire [2:0]  irq_event;
	integer     k;

	assign irq_clear = (reg_write && reg_addr == `UIED_IRQ_CLEAR) ?
		reg_wdata[2:0] : 3'h0;

	genvar i;
	generate
		for (i = 0; i < 3; i = i + 1) begin : g_ep
			wire [15:0] base;
			assign base = (i == 0) ? `UIED_EP1_BASE :
				(i == 1) ? `UIED_EP2_BASE : `UIED_EP3_BASE;
			// block decode on the upper address bits
			assign hit[i] = (reg_addr[15:3] == base[15:3]);
			// completion counts only on a usable endpoint with enable set
			assign irq_event[i] = bm_done[i] & ep_usable[i] &
				cfg_all[8*i+`UIED_BIT_IE];
			assign ep_stall[i] = cfg_all[8*i+`UIED_BIT_STALL];
			uied_ep_desc u_ep (
				.clock         (clock),
				.reset         (reset),
				.wr_en         (reg_write & hit[i]),
				.wr_off        (reg_addr[2:0]),
				.wr_data       (reg_wdata),
				.bm_done       (bm_done[i] & ep_usable[i]),
				.bm_stall_set  (bm_stall_set[i]),
				.bm_stall_sent (bm_stall_sent[i]),
				.bm_load       (bm_load[i] & ep_usable[i]),
				.cfg           (cfg_all[8*i+7:8*i]),
				.xbase         (xbase_all[8*i+7:8*i]),
				.xcnt          (xcnt_all[8*i+7:8*i]),
				.ybase         (ybase_all[8*i+7:8*i]),
				.ycnt          (ycnt_all[8*i+7:8*i]),
				.start_addr    (ep_start_addr[11*i+10:11*i]),
				.sel_count     (ep_count[7*i+6:7*i]),
				.sel_ready     (ep_ready[i]),
				.ep_usable     (ep_usable[i])
			);
		end
	endgenerate

	// sticky status; a new event beats a clear in the same cycle
	always @(posedge clock or posedge reset) begin
		if (reset) begin
			irq_status_q <= 3'h0;
			irq_enable_q <= 3'h0;
		end else begin
			irq_status_q <= (irq_status_q & ~irq_clear) | irq_event;
			if (reg_write && reg_addr == `UIED_IRQ_ENABLE)
				irq_enable_q <= reg_wdata[2:0];
		end
	end

	assign irq = |(irq_status_q & irq_enable_q);

	// read mux over endpoint blocks and interrupt registers
	always @* begin
		rd_d = 8'h00;
		for (k = 0; k < 3; k = k + 1) begin
			if (hit[k]) begin
				case (reg_addr[2:0])
					`UIED_OFF_CFG:   rd_d = cfg_all[8*k+:8];
					`UIED_OFF_XBASE: rd_d = xbase_all[8*k+:8];
					`UIED_OFF_XCNT:  rd_d = xcnt_all[8*k+:8];
					`UIED_OFF_YBASE: rd_d = ybase_all[8*k+:8];
					`UIED_OFF_YCNT:  rd_d = ycnt_all[8*k+:8];
					default:         rd_d = 8'h00;
				endcase
			end
		end
		if (reg_addr == `UIED_IRQ_STATUS)
			rd_d = {5'h00, irq_status_q};
		if (reg_addr == `UIED_IRQ_ENABLE)
			rd_d = {5'h00, irq_enable_q};
	end

	// read data only in the cycle after the strobe
	always @(posedge clock or posedge reset) begin
		if (reset)
			reg_rdata <= 8'h00;
		else if (reg_read)
			reg_rdata <= rd_d;
		else
			reg_rdata <= 8'h00;
	end
endmodule

// >>> uied_defines.vh
// Purpose: constants for the input endpoint descriptor block
// Assumes: byte-wide register port, one clock, async active-high reset
// Notes:   three endpoints, each with an eight-byte descriptor block
// What this block does
// - each endpoint config at its own base; buffers at fixed offsets.
// - completion interrupt enable decides if a finished transfer interrupts.
// - stall is set by buffer manager; firmware may set or clear it.
// - firmware-set stall answers host with STALL, then clears itself.
// - double-buffer off uses X only; on, toggle picks X or Y.
// - toggle bit tracks DATA0/DATA1 sequence, naming the next data PID.
// - buffer-manager enable clear forbids serving the endpoint.
// - base register holds address bits 10..3; three zero bits appended.
// - transactions start at base; base is left unchanged afterwards.
// - seven-bit count encodes 0..64 bytes; above 64 is undefined.
// - Y base register at its own offset, same layout as X.
// - NAK flag 0 means valid packet ready, 1 means empty and NAK.
`ifndef UIED_DEFINES_VH
`define UIED_DEFINES_VH
`define UIED_EP1_BASE     16'hff48
`define UIED_EP2_BASE     16'hff50
`define UIED_EP3_BASE     16'hff58
`define UIED_OFF_CFG      3'h0
`define UIED_OFF_XBASE    3'h1
`define UIED_OFF_XCNT     3'h2
`define UIED_OFF_YBASE    3'h5
`define UIED_OFF_YCNT     3'h6
`define UIED_IRQ_STATUS   16'hff60
`define UIED_IRQ_ENABLE   16'hff61
`define UIED_IRQ_CLEAR    16'hff62
`define UIED_BIT_IE       2
`define UIED_BIT_STALL    3
`define UIED_BIT_DOUBLE_BUFFER_ENABLE     4
`define UIED_BIT_TOGGLE   5
`define UIED_BIT_ISO      6
`define UIED_BIT_BUFMGR_USE_ENABLE     7
`define UIED_BIT_NAK      7
`define UIED_CFG_RESET    8'h00
`define UIED_CFG_WMASK    8'hfc
`define UIED_CNT_RESET    8'h80
`define UIED_BYTE_RESET   8'h00
`define UIED_CNT_MAX      7'h40
`endif

// >>> uied_ep_desc.v
// Purpose: one input endpoint descriptor (config, bases, counts)
// Assumes: writes from firmware and events from buffer manager same clock
// Notes:   hardware events win over firmware writes in the same cycle
`timescale 1ns/1ns
`include "uied_defines.vh"
module uied_ep_desc (
	// clock and reset
	input  wire        clock,
	input  wire        reset,
	// firmware write port, already decoded to this endpoint
	input  wire        wr_en,
	input  wire [2:0]  wr_off,
	input  wire [7:0]  wr_data,
	// buffer manager events
	input  wire        bm_done,
	input  wire        bm_stall_set,
	input  wire        bm_stall_sent,
	input  wire        bm_load,
	// descriptor contents
	output wire [7:0]  cfg,
	output wire [7:0]  xbase,
	output wire [7:0]  xcnt,
	output wire [7:0]  ybase,
	output wire [7:0]  ycnt,
	// buffer selection toward the buffer manager
	output wire [10:0] start_addr,
	output wire [6:0]  sel_count,
	output wire        sel_ready,
	output wire        ep_usable
);
	reg  [7:0] cfg_q;
	reg  [7:0] cfg_d;
	reg  [7:0] xbase_q;
	reg  [7:0] ybase_q;
	reg  [7:0] xcnt_q;
	reg  [7:0] xcnt_d;
	reg  [7:0] ycnt_q;
	reg  [7:0] ycnt_d;
	wire       use_y;

	// y only with double buffering and toggle high
	assign use_y = cfg_q[`UIED_BIT_DOUBLE_BUFFER_ENABLE] &
		cfg_q[`UIED_BIT_TOGGLE];
	// base with three zero low bits; base never altered by hardware
	assign start_addr = use_y ? {ybase_q, 3'b000} :
		{xbase_q, 3'b000};
	assign sel_count = use_y ? ycnt_q[6:0] : xcnt_q[6:0];
	// nak low means a packet waits for the host
	assign sel_ready = use_y ? ~ycnt_q[`UIED_BIT_NAK] :
		~xcnt_q[`UIED_BIT_NAK];
	// manager serves only enabled, unstalled endpoints
	assign ep_usable = cfg_q[`UIED_BIT_BUFMGR_USE_ENABLE] &
		~cfg_q[`UIED_BIT_STALL];
	assign cfg   = cfg_q;
	assign xbase = xbase_q;
	assign xcnt  = xcnt_q;
	assign ybase = ybase_q;
	assign ycnt  = ycnt_q;

	// next config: firmware write, then hardware updates on top
	always @* begin
		cfg_d = cfg_q;
		xcnt_d = xcnt_q;
		ycnt_d = ycnt_q;
		if (wr_en && wr_off == `UIED_OFF_CFG)
			cfg_d = wr_data & `UIED_CFG_WMASK;
		if (wr_en && wr_off == `UIED_OFF_XCNT)
			xcnt_d = wr_data;
		if (wr_en && wr_off == `UIED_OFF_YCNT)
			ycnt_d = wr_data;
		if (bm_stall_sent)
			cfg_d[`UIED_BIT_STALL] = 1'b0;
		if (bm_stall_set)
			cfg_d[`UIED_BIT_STALL] = 1'b1;
		if (bm_done) begin
			// packet gone: flip toggle, mark the used buffer empty
			cfg_d[`UIED_BIT_TOGGLE] = ~cfg_q[`UIED_BIT_TOGGLE];
			if (use_y)
				ycnt_d[`UIED_BIT_NAK] = 1'b1;
			else
				xcnt_d[`UIED_BIT_NAK] = 1'b1;
		end
		if (bm_load) begin
			if (use_y)
				ycnt_d[`UIED_BIT_NAK] = 1'b0;
			else
				xcnt_d[`UIED_BIT_NAK] = 1'b0;
		end
	end

	// descriptor storage
	always @(posedge clock or posedge reset) begin
		if (reset) begin
			cfg_q   <= `UIED_CFG_RESET;
			xbase_q <= `UIED_BYTE_RESET;
			ybase_q <= `UIED_BYTE_RESET;
			xcnt_q  <= `UIED_CNT_RESET;
			ycnt_q  <= `UIED_CNT_RESET;
		end else begin
			cfg_q  <= cfg_d;
			xcnt_q <= xcnt_d;
			ycnt_q <= ycnt_d;
			if (wr_en && wr_off == `UIED_OFF_XBASE)
				xbase_q <= wr_data;
			if (wr_en && wr_off == `UIED_OFF_YBASE)
				ybase_q <= wr_data;
		end
	end
endmodule

// >>> uied_top_monitor.sv
// Purpose: port checks for the input endpoint descriptor block
// Assumes: one clock, async active-high reset
// Notes:   sees only the top ports, bound below
`timescale 1ns/1ns
module uied_mon (
	// clock and reset
	input wire        clock,
	input wire        reset,
	// register port
	input wire [15:0] reg_addr,
	input wire [7:0]  reg_wdata,
	input wire        reg_write,
	input wire        reg_read,
	input wire [7:0]  reg_rdata,
	// manager events
	input wire [2:0]  bm_done,
	input wire [2:0]  bm_stall_set,
	input wire [2:0]  bm_stall_sent,
	input wire [2:0]  bm_load,
	// manager view and interrupt
	input wire [32:0] ep_start_addr,
	input wire [20:0] ep_count,
	input wire [2:0]  ep_ready,
	input wire [2:0]  ep_usable,
	input wire [2:0]  ep_stall,
	input wire        irq
);
	// one domain, so clock and reset are given once
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	chk_rdata_idle: assert property (
		!reg_read |=> reg_rdata == 8'h00)
		else $error("read data nonzero without a read");
	chk_addr_align: assert property ((ep_start_addr[2:0] |
		ep_start_addr[13:11] | ep_start_addr[24:22]) == 3'h0)
		else $error("start address low bits not zero");
	chk_stall_set: assert property (bm_stall_set[0] |=> ep_stall[0])
		else $error("manager stall not taken");
	chk_stall_drop: assert property (
		bm_stall_sent[1] && !bm_stall_set[1] |=> !ep_stall[1])
		else $error("stall kept after handshake");
	chk_stall_block: assert property (
		bm_stall_set != 3'h0 |=> (ep_usable & $past(bm_stall_set)) == 3'h0)
		else $error("stalled endpoint offered as usable");
	chk_done_gated: assert property (
		bm_done != 3'h0 && (bm_done & ep_usable) == 3'h0 &&
		!reg_write && !irq |=> !irq)
		else $error("interrupt from an endpoint not in use");
	chk_load_ready: assert property (bm_load[2] && ep_usable[2] &&
		!reg_write && !bm_done[2] |=> ep_ready[2])
		else $error("loaded buffer not ready");
	chk_irq_off: assert property (
		reg_write && reg_addr == 16'hff61 && reg_wdata == 8'h00 |=> !irq)
		else $error("interrupt with all enables off");
	chk_base_hold: assert property (
		!reg_write && bm_done == 3'h0 |=> $stable(ep_start_addr))
		else $error("start address moved without a cause");
endmodule
bind uied_top uied_mon u_mon (.*);

// >>> uied_bm_model.sv
// Purpose: buffer manager stand-in that issues event pulses
// Assumes: pulses last one clock, launched after a rising edge
// Notes:   done and load only for usable endpoints unless told to misbehave; stall pulses always go out
`timescale 1ns/1ns
module uied_bm_model (
	// clock
	input  wire       clock,
	// descriptor view
	input  wire [2:0] ep_usable,
	// event pulses
	output reg  [2:0] bm_done,
	output reg  [2:0] bm_load,
	output reg  [2:0] bm_stall_set,
	output reg  [2:0] bm_stall_sent
);
	// idle between events
	initial {bm_done, bm_load, bm_stall_set, bm_stall_sent} = 12'h000;
	// kind 0 done, 1 load, 2 stall set, 3 stall sent
	task pulse(input [1:0] kind, input [1:0] n, input rude);
		reg [2:0] m;
		begin
			@(posedge clock);
			m = (rude || kind[1] || ep_usable[n]) ? 3'h1 << n : 3'h0;
			{bm_done, bm_load, bm_stall_set, bm_stall_sent} <=
				{m, 9'h000} >> (3 * kind);
			@(posedge clock);
			{bm_done, bm_load, bm_stall_set, bm_stall_sent} <= 12'h000;
		end
	endtask
endmodule

// >>> uied_top_test.sv
// Purpose: self-checking bench for the endpoint descriptor block
// Assumes: reads answer one cycle after the strobe
// Notes:   random descriptors plus stall, load and interrupt cases
`timescale 1ns/1ns
module uied_top_test;
	reg         clock = 1'b0;
	reg         reset = 1'b1;
	reg  [15:0] reg_addr = 16'h0000;
	reg  [7:0]  reg_wdata = 8'h00;
	reg         reg_write = 1'b0;
	reg         reg_read = 1'b0;
	wire [7:0]  reg_rdata;
	wire [2:0]  bm_done, bm_load, bm_stall_set, bm_stall_sent;
	wire [2:0]  ep_ready, ep_usable, ep_stall;
	wire [32:0] ep_start_addr;
	wire [20:0] ep_count;
	wire        irq;
	integer     error_cnt = 0;
	integer     comparisons = 0;
	reg  [15:0] b;
	reg  [1:0]  n;
	reg  [7:0]  c, xb, xc, yb, yc;
	// 250 MHz
	always #2 clock = ~clock;
	uied_top u_dut (.*);
	uied_bm_model u_bm (.*);
	task check(input [32:0] got, input [32:0] exp);
		begin
			comparisons = comparisons + 1;
			if (got !== exp) begin
				error_cnt = error_cnt + 1;
				$display("unexpected at %0t: saw %h want %h", $time, got, exp);
			end
		end
	endtask
	// a gap cycle after each strobe keeps one assignment per time step
	task wr(input [15:0] a, input [7:0] d);
		begin
			@(posedge clock);
			reg_addr <= a;
			reg_wdata <= d;
			reg_write <= 1'b1;
			@(posedge clock);
			reg_write <= 1'b0;
		end
	endtask
	task rd(input [15:0] a, input [7:0] e);
		begin
			@(posedge clock);
			reg_addr <= a;
			reg_read <= 1'b1;
			@(posedge clock);
			reg_read <= 1'b0;
			@(negedge clock);
			check(reg_rdata, e);
		end
	endtask
	function [7:0] sel(input [7:0] f, input [7:0] x, input [7:0] y);
		sel = (f[4] & f[5]) ? y : x;
	endfunction
	task end_of_test;
		begin
			$display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
			if (error_cnt == 0 && comparisons > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask
	// hang guard at 5000 cycles, far beyond the roughly 130 cycles used
	initial begin
		#20000;
		error_cnt = error_cnt + 1;
		end_of_test;
	end
	initial begin
		void'($urandom(32'ha011));
		repeat (2) @(posedge clock);
		reset <= 1'b0;
		// reset values, then random descriptors per endpoint
		for (b = 16'hff48; b < 16'hff60; b = b + 16'h0008) begin
			n = b[4:3] - 2'h1;
			rd(b, 8'h00);
			rd(b + 16'h2, 8'h80);
			c = 8'($urandom) & 8'hb4;
			xb = 8'($urandom);
			yb = 8'($urandom);
			xc = {1'b1, 7'($urandom % 65)};
			yc = {1'b1, 7'($urandom % 65)};
			wr(b, c | 8'h03);
			wr(b + 16'h1, xb);
			wr(b + 16'h2, xc);
			wr(b + 16'h5, yb);
			wr(b + 16'h6, yc);
			rd(b, c);
			rd(b + 16'h1, xb);
			rd(b + 16'h2, xc);
			rd(b + 16'h5, yb);
			rd(b + 16'h6, yc);
			rd(b + 16'h3, 8'h00);
			check(ep_start_addr[11 * n +: 11], {sel(c, xb, yb), 3'h0});
			check(ep_count[7 * n +: 7], sel(c, xc, yc) & 8'h7f);
			check(ep_ready[n], 1'b0);
		end
		// firmware stall answered by the handshake
		wr(16'hff50, 8'h88);
		rd(16'hff50, 8'h88);
		check(ep_usable[1], 1'b0);
		u_bm.pulse(2'h3, 2'h1, 1'b0);
		rd(16'hff50, 8'h80);
		check(ep_usable[1], 1'b1);
		u_bm.pulse(2'h2, 2'h0, 1'b0);
		@(negedge clock);
		check(ep_stall[0], 1'b1);
		wr(16'hff48, 8'h80);
		rd(16'hff48, 8'h80);
		check(ep_stall[0], 1'b0);
		// double-buffered load on X, finish, interrupt, then Y in use
		wr(16'hff58, 8'h94);
		wr(16'hff5a, 8'hc0);
		wr(16'hff61, 8'h07);
		u_bm.pulse(2'h1, 2'h2, 1'b0);
		@(negedge clock);
		check(ep_ready[2], 1'b1);
		u_bm.pulse(2'h0, 2'h2, 1'b0);
		rd(16'hff60, 8'h04);
		check(irq, 1'b1);
		rd(16'hff58, 8'hb4);
		rd(16'hff5a, 8'hc0);
		rd(16'hff59, xb);
		check(ep_start_addr[32:22], {yb, 3'h0});
		check(ep_count[20:14], yc & 8'h7f);
		check(ep_ready[2], 1'b0);
		wr(16'hff62, 8'h04);
		rd(16'hff60, 8'h00);
		check(irq, 1'b0);
		// manager use off: load and finish are both ignored
		wr(16'hff58, 8'h04);
		u_bm.pulse(2'h1, 2'h2, 1'b1);
		@(negedge clock);
		check(ep_ready[2], 1'b0);
		u_bm.pulse(2'h0, 2'h2, 1'b1);
		rd(16'hff60, 8'h00);
		rd(16'hff58, 8'h04);
		check(irq, 1'b0);
		wr(16'hff61, 8'h00);
		end_of_test;
	end
endmodule
